// ==== src/tza_top.sv ====
// Purpose: conversion scheduling, zone select and alarm logic
// Assumes: adc_temp holds the converter result of the selected zone
// Notes:   one wait state on every Avalon access
`timescale 1ns/1ps
`include "tza_cfg.svh"
module tza_top import tza_pkg::*; #(
    parameter int unsigned CONV_CYCLES = `TZA_CONV_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        scl_pin,
    input  wire logic        sda_pin,
    input  wire logic [2:0]  addr_pins,
    input  wire logic [8:0]  adc_temp,
    output logic             zone_sel,
    output logic             alarm_o,
    output logic             alarm_oe
);
    localparam int unsigned CW = $clog2(CONV_CYCLES + 1);
    localparam logic [CW-1:0] CONV_LAST = CW'(CONV_CYCLES - 1);

    function automatic logic [8:0] thr_wr(input logic [8:0]  old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  be);
        thr_wr = {be[1] ? wd[15:8] : old[8:1], be[0] ? wd[7] : old[0]};
    endfunction

    // half-degree two's complement compare
    function automatic logic t_gt(input logic [8:0] a, input logic [8:0] b);
        t_gt = $signed(a) > $signed(b);
    endfunction

    function automatic logic [2:0] fq_depth(input logic [1:0] code);
        logic [2:0] d;
        d = `TZA_FQ_DEPTH0;
        unique case (code)
            2'h0: d = `TZA_FQ_DEPTH0;
            2'h1: d = `TZA_FQ_DEPTH1;
            2'h2: d = `TZA_FQ_DEPTH2;
            2'h3: d = `TZA_FQ_DEPTH3;
        endcase
        fq_depth = d;
    endfunction

    logic [4:0]    pins_s;
    logic          watch_hit;
    logic          watch_active;

    tza_sync #(
        .W   (5),
        .RST (`TZA_PIN_RST)
    ) u_sync (
        .clk   (clk),
        .reset (reset),
        .d     ({addr_pins, sda_pin, scl_pin}),
        .q     (pins_s)
    );

    tza_bus_watch u_watch (
        .clk         (clk),
        .reset       (reset),
        .scl         (pins_s[0]),
        .sda         (pins_s[1]),
        .dev_addr    ({`TZA_ADDR_BASE, pins_s[4:2]}),
        .addr_hit    (watch_hit),
        .xfer_active (watch_active)
    );

    // bus slave: request answered one cycle after it appears
    logic          ack_ff;
    logic [31:0]   rdata_ff;
    logic [31:0]   rd_mux;
    wire  [2:0]    idx     = avs_address[4:2];
    wire           req     = avs_read | avs_write;
    wire           wr_fire = avs_write & ack_ff;
    wire           rd_fire = avs_read & ack_ff;
    wire           rd_load = avs_read & ~ack_ff;

    // registers: a single config and threshold pair serve both zones
    tza_cfg_t      cfg_ff;
    logic          sts_ff;
    logic [8:0]    hyst_ff;
    logic [8:0]    set_ff;
    logic [8:0]    temp_ff;

    wire           wr_cfg   = wr_fire & (idx == `TZA_IDX_CFG) & avs_byteenable[0];
    wire           wr_hyst  = wr_fire & (idx == `TZA_IDX_HYST);
    wire           wr_set   = wr_fire & (idx == `TZA_IDX_SET);
    wire           rd_cfg   = rd_fire & (idx == `TZA_IDX_CFG);
    wire tza_cfg_t cfg_wd   = tza_cfg_t'(avs_writedata[6:0]);
    wire           zone_chg = wr_cfg & (avs_writedata[`TZA_CFG_ZONE] != cfg_ff.zone);
    wire           mode_chg = wr_cfg & (avs_writedata[`TZA_CFG_MODE] != cfg_ff.mode);

    // conversion scheduling
    logic [CW-1:0] conv_cnt_ff;
    logic [CW-1:0] nxt_conv_cnt;
    logic          halt_ff;
    wire           running   = ~cfg_ff.shdn & ~halt_ff;
    wire           conv_done = running & (conv_cnt_ff == CONV_LAST);
    wire           restart   = watch_hit | zone_chg | cfg_ff.shdn;
    // stays halted while our transaction is open, clears at its stop
    wire           nxt_halt  = watch_hit | (halt_ff & watch_active);

    always_comb begin
        nxt_conv_cnt = conv_cnt_ff;
        if (restart || conv_done) begin
            nxt_conv_cnt = '0;
        end else if (running) begin
            nxt_conv_cnt = conv_cnt_ff + CW'(1);
        end
    end

    // alarm search: one counter serves both directions
    logic          armed_under_ff;
    logic [2:0]    fault_cnt_ff;
    logic [2:0]    nxt_fault_cnt;
    logic          pend_ff;
    logic          oe_ff;
    wire  [2:0]    depth    = fq_depth(cfg_ff.fq);
    wire           over     = t_gt(adc_temp, set_ff);
    wire           under    = t_gt(hyst_ff, adc_temp);
    wire           cond     = armed_under_ff ? under : over;
    wire           evt      = conv_done & cond & (fault_cnt_ff == depth - 3'h1);
    wire           nxt_arm  = mode_chg ? 1'b0 : (evt ? ~armed_under_ff : armed_under_ff);
    // set wins over the clearing read
    wire           nxt_sts  = evt | (sts_ff & ~rd_cfg);
    wire           nxt_pend = (evt & cfg_ff.mode) | (pend_ff & ~rd_cfg & ~mode_chg);
    // comparator level is the search direction, untouched by reads
    wire           alarm    = cfg_ff.mode ? pend_ff : armed_under_ff;
    wire           nxt_oe   = ~cfg_ff.mask & (cfg_ff.alarm_polarity_bit ? ~alarm : alarm);

    // any config write restarts the queue so results land depth conversions later
    always_comb begin
        nxt_fault_cnt = fault_cnt_ff;
        if (wr_cfg) begin
            nxt_fault_cnt = 3'h0;
        end else if (conv_done) begin
            nxt_fault_cnt = (cond && !evt) ? fault_cnt_ff + 3'h1 : 3'h0;
        end
    end

    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (idx)
            `TZA_IDX_TEMP: rd_mux = {16'h0000, temp_ff, 7'h00};
            `TZA_IDX_CFG:  rd_mux = {24'h00_0000, sts_ff, cfg_ff};
            `TZA_IDX_HYST: rd_mux = {16'h0000, hyst_ff, 7'h00};
            `TZA_IDX_SET:  rd_mux = {16'h0000, set_ff, 7'h00};
            `TZA_IDX_STAT: rd_mux = {28'h000_0000, watch_active, halt_ff,
                                     armed_under_ff, running};
            default:       rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ack_ff   <= 1'b0;
            rdata_ff <= 32'h0000_0000;
        end else begin
            ack_ff <= req & ~ack_ff;
            if (rd_load) begin
                rdata_ff <= rd_mux;
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cfg_ff  <= tza_cfg_t'(`TZA_CFG_RST);
            hyst_ff <= `TZA_HYST_RST;
            set_ff  <= `TZA_SET_RST;
        end else begin
            if (wr_cfg) begin
                cfg_ff <= cfg_wd;
            end
            if (wr_hyst) begin
                hyst_ff <= thr_wr(hyst_ff, avs_writedata, avs_byteenable);
            end
            if (wr_set) begin
                set_ff <= thr_wr(set_ff, avs_writedata, avs_byteenable);
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            conv_cnt_ff <= '0;
            halt_ff     <= 1'b0;
            temp_ff     <= `TZA_TEMP_RST;
        end else begin
            conv_cnt_ff <= nxt_conv_cnt;
            halt_ff     <= nxt_halt;
            if (conv_done) begin
                temp_ff <= adc_temp;
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            armed_under_ff <= 1'b0;
            fault_cnt_ff   <= 3'h0;
            sts_ff         <= 1'b0;
            pend_ff        <= 1'b0;
            oe_ff          <= 1'b0;
        end else begin
            armed_under_ff <= nxt_arm;
            fault_cnt_ff   <= nxt_fault_cnt;
            sts_ff         <= nxt_sts;
            pend_ff        <= nxt_pend;
            oe_ff          <= nxt_oe;
        end
    end

    assign avs_waitrequest = req & ~ack_ff;
    assign avs_readdata    = rdata_ff;
    assign zone_sel        = cfg_ff.zone;
    // open drain: the pin is only ever pulled low
    assign alarm_o         = 1'b0;
    assign alarm_oe        = oe_ff;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    a_zone_restart: assert property (zone_chg |=> conv_cnt_ff == '0)
        else $error("zone change did not restart conversion");

    a_match_halts: assert property (watch_hit |=> halt_ff && conv_cnt_ff == '0)
        else $error("address match did not halt conversion");

    a_halt_holds: assert property (halt_ff && watch_active && !watch_hit
                                   |=> halt_ff && $stable(conv_cnt_ff))
        else $error("conversion resumed inside transaction");

    a_halt_ends: assert property ($fell(watch_active) && !watch_hit |-> ##1 !halt_ff)
        else $error("conversion stayed halted after stop");

    a_conv_bound: assert property (conv_cnt_ff <= CONV_LAST)
        else $error("conversion counter passed its bound");

    a_fq_depth: assert property (fault_cnt_ff < depth)
        else $error("fault queue passed its depth");

    a_read_clears: assert property (rd_cfg && !evt |=> !sts_ff && !pend_ff)
        else $error("config read left status set");

    a_evt_sets_sts: assert property (evt |=> sts_ff)
        else $error("event did not set status");

    a_sts_readback: assert property (rd_load && idx == `TZA_IDX_CFG
                                     |=> rdata_ff[7] == $past(sts_ff))
        else $error("config msb does not show status");

    a_mask_hiz: assert property (cfg_ff.mask |=> !alarm_oe)
        else $error("masked alarm pin driven");

    a_pol_low: assert property (!cfg_ff.mask && !cfg_ff.alarm_polarity_bit && cfg_ff.mode && pend_ff
                                ##0 $stable(cfg_ff) |=> alarm_oe)
        else $error("active low alarm not driven");

    a_alternate: assert property (evt && !mode_chg
                                  |=> armed_under_ff != $past(armed_under_ff))
        else $error("event did not flip search direction");

    a_mode_rearm: assert property (mode_chg |=> !armed_under_ff && fault_cnt_ff == 3'h0)
        else $error("mode change did not rearm over search");

    a_one_wait: assert property (req && !ack_ff |=> ack_ff && !avs_waitrequest)
        else $error("bus answer not after one wait state");

    a_ack_single: assert property (ack_ff |=> !ack_ff)
        else $error("bus answer held for two cycles");

    a_temp_capture: assert property (conv_done |=> temp_ff == $past(adc_temp))
        else $error("result not captured at conversion end");

    a_zone_follows: assert property (wr_cfg |=> zone_sel == $past(cfg_wd.zone))
        else $error("zone select does not follow config write");

    a_shdn_holds: assert property (cfg_ff.shdn |=> conv_cnt_ff == '0)
        else $error("conversion ran in shutdown");

    a_sts_holds: assert property (sts_ff && !rd_cfg |=> sts_ff)
        else $error("status dropped without config read");

    a_pend_on_evt: assert property (evt && cfg_ff.mode |=> pend_ff)
        else $error("interrupt event left no pending request");

    a_pol_high: assert property (cfg_ff.alarm_polarity_bit && cfg_ff.mode && !cfg_ff.mask && pend_ff
                                 |=> !alarm_oe)
        else $error("active high alarm pin still driven");

    a_cmp_level: assert property (
        !cfg_ff.mask && !cfg_ff.alarm_polarity_bit && !cfg_ff.mode && armed_under_ff |=> alarm_oe)
        else $error("comparator alarm not driven");

    a_cmp_no_clear: assert property (rd_cfg && !evt |=> $stable(armed_under_ff))
        else $error("read changed comparator level");

endmodule // tza_top

// ==== src/tza_cfg.svh ====
// Purpose: constants of the thermal zone alarm control block
// Assumes: 125 MHz clk, registers reached by word index over Avalon-MM
// Notes:   byte address of a register is four times its index
`ifndef TZA_CFG_SVH
`define TZA_CFG_SVH

`define TZA_IDX_TEMP     3'h0
`define TZA_IDX_CFG      3'h1
`define TZA_IDX_HYST     3'h2
`define TZA_IDX_SET      3'h3
`define TZA_IDX_STAT     3'h4

`define TZA_CFG_SHDN     0
`define TZA_CFG_MODE     1
`define TZA_CFG_POL      2
`define TZA_CFG_ZONE     5
`define TZA_CFG_MASK     6

`define TZA_CFG_RST      7'h00
`define TZA_HYST_RST     9'h096
`define TZA_SET_RST      9'h0a0
`define TZA_TEMP_RST     9'h000

`define TZA_FQ_DEPTH0    3'h1
`define TZA_FQ_DEPTH1    3'h2
`define TZA_FQ_DEPTH2    3'h4
`define TZA_FQ_DEPTH3    3'h6

`define TZA_CONV_TIME_MS 160
`define TZA_CLK_MHZ      125
`define TZA_CONV_CYCLES  (`TZA_CONV_TIME_MS * 1000 * `TZA_CLK_MHZ)

// upper four bits of the serial slave address; value is arbitrary
`define TZA_ADDR_BASE    4'h5
// idle level of {a2, a1, a0, sda, scl} while reset
`define TZA_PIN_RST      5'h03

`endif

// ==== src/tza_pkg.sv ====
// Purpose: types of the thermal zone alarm control block
// Assumes: constants live in tza_cfg.svh
// Notes:   field order of tza_cfg_t matches config bits 6..0
package tza_pkg;

    typedef struct packed {
        logic       mask;
        logic       zone;
        logic [1:0] fq;
        logic       alarm_polarity_bit;
        logic       mode;
        logic       shdn;
    } tza_cfg_t;

    typedef enum logic [1:0] {
        WS_IDLE,
        WS_ADDR,
        WS_MATCH,
        WS_OTHER
    } tza_wst_t;

endpackage

// ==== src/tza_sync.sv ====
// Purpose: three-flop pin synchroniser with agreement filter
// Assumes: inputs are asynchronous to clk
// Notes:   output changes only once stages two and three agree
`timescale 1ns/1ps
module tza_sync #(
    parameter int unsigned W   = 1,
    parameter logic [W-1:0] RST = '0
) (
    input  wire logic         clk,
    input  wire logic         reset,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] s1_ff;
    logic [W-1:0] s2_ff;
    logic [W-1:0] s3_ff;
    logic [W-1:0] q_ff;
    wire  [W-1:0] agree = ~(s2_ff ^ s3_ff);
    wire  [W-1:0] nxt_q = (agree & s3_ff) | (~agree & q_ff);

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s1_ff <= RST;
            s2_ff <= RST;
            s3_ff <= RST;
            q_ff  <= RST;
        end else begin
            s1_ff <= d;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            q_ff  <= nxt_q;
        end
    end

    assign q = q_ff;
endmodule // tza_sync

// ==== src/tza_bus_watch.sv ====
// Purpose: watches the serial bus for start, own address and stop
// Assumes: scl and sda are already synchronised levels
// Notes:   does not acknowledge; the serial data path sits elsewhere
`timescale 1ns/1ps
module tza_bus_watch import tza_pkg::*; (
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic       scl,
    input  wire logic       sda,
    input  wire logic [6:0] dev_addr,
    output logic            addr_hit,
    output logic            xfer_active
);
    tza_wst_t   st_ff;
    tza_wst_t   nxt_st;
    logic       scl_d_ff;
    logic       sda_d_ff;
    logic [5:0] sh_ff;
    logic [5:0] nxt_sh;
    logic [2:0] cnt_ff;
    logic [2:0] nxt_cnt;
    logic       hit_ff;
    logic       nxt_hit;
    logic       match_ff;
    logic       nxt_match;

    wire start = scl & scl_d_ff & sda_d_ff & ~sda;
    wire stop  = scl & scl_d_ff & ~sda_d_ff & sda;
    wire rise  = scl & ~scl_d_ff;
    wire [6:0] addr_now = {sh_ff, sda};

    always_comb begin
        nxt_st    = st_ff;
        nxt_sh    = sh_ff;
        nxt_cnt   = cnt_ff;
        nxt_hit   = 1'b0;
        nxt_match = match_ff;
        if (stop) begin
            nxt_st    = WS_IDLE;
            nxt_match = 1'b0;
        end else if (start) begin
            nxt_st  = WS_ADDR;
            nxt_cnt = 3'h0;
        end else begin
            unique case (st_ff)
                WS_ADDR: begin
                    if (rise) begin
                        nxt_sh  = addr_now[5:0];
                        nxt_cnt = cnt_ff + 3'h1;
                        if (cnt_ff == 3'h6) begin
                            if (addr_now == dev_addr) begin
                                nxt_st    = WS_MATCH;
                                nxt_hit   = 1'b1;
                                nxt_match = 1'b1;
                            end else begin
                                nxt_st = WS_OTHER;
                            end
                        end
                    end
                end
                WS_IDLE, WS_MATCH, WS_OTHER: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st_ff    <= WS_IDLE;
            scl_d_ff <= 1'b1;
            sda_d_ff <= 1'b1;
            sh_ff    <= 6'h00;
            cnt_ff   <= 3'h0;
            hit_ff   <= 1'b0;
            match_ff <= 1'b0;
        end else begin
            st_ff    <= nxt_st;
            scl_d_ff <= scl;
            sda_d_ff <= sda;
            sh_ff    <= nxt_sh;
            cnt_ff   <= nxt_cnt;
            hit_ff   <= nxt_hit;
            match_ff <= nxt_match;
        end
    end

    assign addr_hit    = hit_ff;
    assign xfer_active = match_ff;
endmodule // tza_bus_watch

// ==== test/tza_i2c_host.sv ====
// Purpose: serial bus host that frames an address toward the block
// Assumes: bus pull-ups, so a released line reads high
// Notes:   clock stands still between frames; no ack is awaited
`timescale 1ns/1ps
module tza_i2c_host #(
    parameter int unsigned LINK_NS = 160
) (
    output logic scl,
    output logic sda
);
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end
    // start, seven address bits msb first, write bit; frame then stays open
    task automatic start_addr(input logic [6:0] a);
        // keep every pin change off the sampling edge of clk
        #1;
        sda = 1'b0;
        #(LINK_NS/2);
        for (int i = 0; i < 8; i++) begin
            scl = 1'b0;
            #(LINK_NS/4);
            sda = (i < 7) ? a[6-i] : 1'b0;
            #(LINK_NS/4);
            scl = 1'b1;
            #(LINK_NS/2);
        end
        scl = 1'b0;
        #(LINK_NS/4);
        sda = 1'b1;
    endtask
    task automatic stop();
        sda = 1'b0;
        #(LINK_NS/4);
        scl = 1'b1;
        #(LINK_NS/4);
        sda = 1'b1;
        #(LINK_NS/2);
    endtask
endmodule // tza_i2c_host

// ==== test/test_thermal_zone_alarm_control.sv ====
// Purpose: self-checking bench of the zone and alarm control block
// Assumes: short conversion count; reads checked from a queue of notes
// Notes:   alarm pin asserted for active low means alarm_oe high
`timescale 1ns/1ps
`include "tza_cfg.svh"
module test_thermal_zone_alarm_control import tza_pkg::*;;
    localparam int unsigned CONV = 400;
    localparam int DQ [4] = '{1, 2, 4, 6};
    localparam logic [4:0] A_TEMP = {`TZA_IDX_TEMP, 2'b00};
    localparam logic [4:0] A_CFG  = {`TZA_IDX_CFG, 2'b00};
    localparam logic [4:0] A_HYST = {`TZA_IDX_HYST, 2'b00};
    localparam logic [4:0] A_SET  = {`TZA_IDX_SET, 2'b00};
    localparam logic [31:0] T_LOW  = 32'h0000c880;  // -55.5 C
    localparam logic [31:0] T_HIGH = 32'h00007f80;  // +127.5 C
    logic        clk, reset, avs_read, avs_write, avs_waitrequest;
    logic        scl_pin, sda_pin, zone_sel, alarm_o, alarm_oe, ok;
    logic [4:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, seed;
    logic [2:0]  addr_pins;
    logic [8:0]  adc_temp;
    logic [31:0] exp_q [$];
    tza_cfg_t    cur;
    int          fails, samples_checked, n;

    tza_top #(.CONV_CYCLES(CONV)) u_dut (
        .clk(clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .scl_pin(scl_pin), .sda_pin(sda_pin), .addr_pins(addr_pins),
        .adc_temp(adc_temp), .zone_sel(zone_sel), .alarm_o(alarm_o), .alarm_oe(alarm_oe));
    tza_i2c_host #(.LINK_NS(160)) u_host (.scl(scl_pin), .sda(sda_pin));

    initial clk = 1'b0;
    always #4 clk = ~clk;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
        samples_checked++;
        if (seen !== want) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, want, seen);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // request held until waitrequest is sampled low at a rising edge
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= ~wr;
        avs_writedata <= d;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 50);
        if (k >= 50) begin
            fails++;
            $display("ERROR waitrequest expected 0 seen %b", avs_waitrequest);
            give_verdict();
        end
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] want);
        exp_q.push_back(want);
        bus(1'b0, a, 32'h0);
    endtask
    task automatic cfgw(input logic [6:0] c);
        cur = c;
        bus(1'b1, A_CFG, {25'h0, c});
    endtask
    task automatic rdcfg(input logic sts);
        rd(A_CFG, {24'h0, sts, cur});
    endtask
    task automatic thr(input logic [31:0] t);
        bus(1'b1, A_SET, t);
        bus(1'b1, A_HYST, t);
    endtask
    task automatic new_temp();
        @(posedge clk);
        seed = lfsr(seed);
        adc_temp <= {1'b0, seed[7:0]} % 9'd200;
    endtask
    task automatic wait_oe(input logic lvl, input int lim, output int cnt);
        cnt = 0;
        @(negedge clk);
        while (alarm_oe !== lvl && cnt < lim) begin
            @(negedge clk);
            cnt++;
        end
        if (cnt >= lim) begin
            fails++;
            $display("ERROR alarm_oe expected %b seen %b", lvl, alarm_oe);
            give_verdict();
        end
    endtask
    task automatic hold(input logic lvl, input int cyc, output logic good);
        good = 1'b1;
        repeat (cyc) begin
            @(negedge clk);
            if (alarm_oe !== lvl) good = 1'b0;
        end
    endtask
    // zone toggle with mode cleared restarts conversion, then mode set rearms over search
    task automatic zone_flip(input logic [1:0] fq);
        cfgw({1'b0, ~cur.zone, 5'h00});
        @(negedge clk);
        check("zone_sel", {31'h0, zone_sel}, {31'h0, cur.zone});
        cfgw({1'b0, cur.zone, fq, 3'b010});
    endtask
    task automatic in_window(input int lo, input int hi);
        check("event cycles", {31'h0, n >= lo && n <= hi}, 32'h1);
    endtask

    always @(posedge clk) begin
        if (avs_read && !avs_waitrequest) begin
            if (exp_q.size() > 0) check("readdata", avs_readdata, exp_q.pop_front());
            else check("read without note", 32'h1, 32'h0);
        end
    end

    initial begin
        reset = 1'b1;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 5'h00;
        avs_writedata = 32'h0;
        seed = 32'h1c9b3c31;
        addr_pins = seed[2:0];
        adc_temp = 9'h032;
        fails = 0;
        samples_checked = 0;
        cur = '0;
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        rd(A_CFG, 32'h0);
        rd(A_HYST, 32'h00004b00);
        rd(A_SET, 32'h00005000);
        bus(1'b1, 5'h14, 32'hffffffff);
        rd(5'h14, 32'h0);
        $display("test reset values done");
        new_temp();
        cfgw(7'h02);
        thr(T_LOW);
        wait_oe(1'b1, 2 * CONV + 20, n);
        check("alarm_o", {31'h0, alarm_o}, 32'h0);
        rd(A_TEMP, {16'h0, adc_temp, 7'h00});
        rdcfg(1'b1);
        repeat (3) @(negedge clk);
        check("alarm_oe", {31'h0, alarm_oe}, 32'h0);
        rdcfg(1'b0);
        $display("test over event done");
        thr(T_HIGH);
        wait_oe(1'b1, CONV + 20, n);
        rdcfg(1'b1);
        thr(T_LOW);
        wait_oe(1'b1, CONV + 20, n);
        rdcfg(1'b1);
        $display("test alternation done");
        cfgw(7'h42);
        thr(T_HIGH);
        hold(1'b0, 2 * CONV + 20, ok);
        check("masked alarm_oe", {31'h0, ok}, 32'h1);
        rdcfg(1'b1);
        $display("test mask done");
        cfgw(7'h06);
        repeat (3) @(negedge clk);
        check("idle high pol", {31'h0, alarm_oe}, 32'h1);
        thr(T_LOW);
        wait_oe(1'b0, CONV + 20, n);
        rdcfg(1'b1);
        wait_oe(1'b1, 10, n);
        $display("test polarity done");
        for (int q = 0; q < 4; q++) begin
            new_temp();
            cfgw({1'b1, cur[5:0]});
            rdcfg(1'b0);
            thr(T_LOW);
            zone_flip(q[1:0]);
            wait_oe(1'b1, DQ[q] * CONV + 20, n);
            in_window(DQ[q] * CONV - 12, DQ[q] * CONV + 8);
            rdcfg(1'b1);
            rd(A_SET, T_LOW);
        end
        $display("test zone and queue done");
        zone_flip(2'b00);
        u_host.start_addr({`TZA_ADDR_BASE, addr_pins});
        rd(5'h10, 32'h0000000c);
        hold(1'b0, 2 * CONV, ok);
        check("halted alarm_oe", {31'h0, ok}, 32'h1);
        u_host.stop();
        wait_oe(1'b1, 2 * CONV, n);
        in_window(CONV - 4, CONV + 16);
        rdcfg(1'b1);
        zone_flip(2'b00);
        u_host.start_addr({`TZA_ADDR_BASE, ~addr_pins});
        wait_oe(1'b1, CONV + 20, n);
        u_host.stop();
        rdcfg(1'b1);
        $display("test address halt done");
        cfgw(7'h00);
        thr(T_LOW);
        wait_oe(1'b1, CONV + 20, n);
        rdcfg(1'b1);
        hold(1'b1, 20, ok);
        check("comparator hold", {31'h0, ok}, 32'h1);
        thr(T_HIGH);
        wait_oe(1'b0, CONV + 20, n);
        cfgw(7'h01);
        rd(5'h10, 32'h0);
        thr(32'h00005000);
        bus(1'b1, A_HYST, 32'h00004b00);
        cfgw(7'h00);
        rd(A_HYST, 32'h00004b00);
        $display("test comparator and restore done");
        give_verdict();
    end
endmodule // test_thermal_zone_alarm_control
